// ### design/uic_int_id_fifo_ctrl.v
`timescale 1ns/100ps
`include "uic_map.vh"

module uic_int_id_fifo_ctrl
(
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Register port
  input  wire [3:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr_stb,
  input  wire       rd_stb,
  output reg  [7:0] rdata,
  // Pending interrupt sources, same clock
  input  wire       pend_line_status,
  input  wire       pend_rx_data,
  input  wire       pend_char_tmo,
  input  wire       pend_tx_holding_empty,
  input  wire       pend_busy,
  // FIFO control
  output reg        fifo_enable,
  output reg        tx_fifo_reset,
  output reg        rx_fifo_reset,
  // Interrupt
  output reg        irq
);

  // Register map, word addresses on the port:
  //   shared location  read: identification code in the low nibble
  //                    write: enable, receive reset, transmit reset
  //   status           sticky reset-occurred flags, write one to clear
  //   mask             enables of the status flags onto the interrupt
  // Every output is taken straight from a flip-flop, so the pulses and
  // the read data appear one cycle after the strobe that caused them.
  // The pending inputs come from logic on this clock and are used as
  // they stand; a source in another domain must be synchronised first.

  // Side index of the per-side FIFO reset logic
  localparam N_SIDE  = 2;
  localparam SIDE_TX = 0;
  localparam SIDE_RX = 1;

  // Registered state beside the outputs
  reg  [1:0]        status_q;  // Sticky reset-occurred flags
  reg  [1:0]        mask_q;    // Interrupt mask, same layout as status

  // Next-state values
  reg  [1:0]        mask_d;
  reg               fifo_enable_d;
  reg  [7:0]        rdata_d;
  reg               irq_d;

  // Decoded strobes
  wire              wr_idfc;
  wire              wr_status;
  wire              wr_mask;

  // Write-side fields of the shared location
  wire              wr_fifo_en_bit;
  wire              wr_rx_rst_bit;
  wire              wr_tx_rst_bit;
  wire              en_change;
  wire [N_SIDE-1:0] rst_req;
  wire [N_SIDE-1:0] rst_d;
  wire [N_SIDE-1:0] status_d;

  // Identification path
  wire [3:0]        interrupt_id;

  // Address match, shared by the write-strobe decodes of the register port; the read mux uses its own case
  function addr_hit;
    input [3:0] a;
    input [3:0] off;
    begin
      addr_hit = (a == off);
    end
  endfunction

  // Priority encoder for the identification code; line status is the
  // most urgent, busy detect the least, and an idle port reads as none.
  // Codes: none 1, holding empty 2, receive data 4, line status 6,
  // busy 7, character timeout c. Only one code is shown at a time, so
  // software must service the source and read again to see the next.
  function [3:0] id_code;
    input ls;
    input rx;
    input tmo;
    input txh;
    input busy;
    begin
      if (ls)
      begin
        id_code = `UIC_ID_LINE_STATUS;
      end
      else if (rx)
      begin
        id_code = `UIC_ID_RX_DATA;
      end
      else if (tmo)
      begin
        id_code = `UIC_ID_CHAR_TMO;
      end
      else if (txh)
      begin
        id_code = `UIC_ID_TXH_EMPTY;
      end
      else if (busy)
      begin
        id_code = `UIC_ID_BUSY;
      end
      else
      begin
        id_code = `UIC_ID_NONE;
      end
    end
  endfunction

  // Write strobes per location; unmapped addresses match none of them
  assign wr_idfc   = wr_stb && addr_hit(addr, `UIC_OFF_IDFC);
  assign wr_status = wr_stb && addr_hit(addr, `UIC_OFF_INT_STATUS);
  assign wr_mask   = wr_stb && addr_hit(addr, `UIC_OFF_INT_MASK);

  // Fields of a write to the shared location
  assign wr_fifo_en_bit = wdata[`UIC_BIT_FIFO_EN];
  assign wr_rx_rst_bit  = wdata[`UIC_BIT_RX_RST];
  assign wr_tx_rst_bit  = wdata[`UIC_BIT_TX_RST];

  // A written enable that differs from the current one resets both
  // sides, even when both reset bits of that write are clear
  assign en_change = wr_fifo_en_bit != fifo_enable;

  // Explicit reset request per side
  assign rst_req[SIDE_TX] = wr_tx_rst_bit;
  assign rst_req[SIDE_RX] = wr_rx_rst_bit;

  // Code of the most urgent pending source, fed to the read path
  assign interrupt_id = id_code(pend_line_status, pend_rx_data, pend_char_tmo,
                                pend_tx_holding_empty, pend_busy);

  // Per-side reset pulse and sticky flag. The pulse lives for one
  // cycle only, so software never has to clear it; the flag records
  // that the pulse happened and stays until written with a one. A
  // pulse in the same cycle as the clear wins, so no event is lost.
  // Status bit order follows side order: transmit low, receive high.
  genvar g;
  generate
    for (g = 0; g < N_SIDE; g = g + 1)
    begin : g_side
      assign rst_d[g]    = wr_idfc && (rst_req[g] || en_change);
      assign status_d[g] = rst_d[g] || (status_q[g] && !(wr_status && wdata[g]));
    end
  endgenerate

  // Next FIFO enable; only a write to the shared location moves it.
  // Rewriting the current value resets only the sides whose reset bits are set.
  always @*
  begin
    fifo_enable_d = fifo_enable;
    if (wr_idfc)
    begin
      fifo_enable_d = wr_fifo_en_bit;
    end
  end

  // Next mask
  always @*
  begin
    mask_d = mask_q;
    if (wr_mask)
    begin
      mask_d = wdata[1:0];
    end
  end

  // Level interrupt from the next status, so a new event shows at once
  always @*
  begin
    irq_d = |(status_d & mask_q);
  end

  // Read mux; the shared location gives the identification only, so a
  // write there never alters what a later read returns
  always @*
  begin
    rdata_d = 8'h00;
    if (rd_stb)
    begin
      case (addr)
        `UIC_OFF_IDFC:
        begin
          rdata_d = {4'h0, interrupt_id};
        end
        `UIC_OFF_INT_STATUS:
        begin
          rdata_d = {6'h00, status_q};
        end
        `UIC_OFF_INT_MASK:
        begin
          rdata_d = {6'h00, mask_q};
        end
        default:
        begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  // FIFO enable, out of reset with the FIFOs on
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fifo_enable <= `UIC_FIFO_EN_RST;
    end
    else
    begin
      fifo_enable <= fifo_enable_d;
    end
  end

  // Self-clearing FIFO reset pulses; each stands for exactly one cycle,
  // and the FIFO pointers treat it as a return to empty
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_fifo_reset <= 1'b0;
      rx_fifo_reset <= 1'b0;
    end
    else
    begin
      tx_fifo_reset <= rst_d[SIDE_TX];
      rx_fifo_reset <= rst_d[SIDE_RX];
    end
  end

  // Sticky status and mask
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_q <= 2'h0;
      mask_q   <= `UIC_MASK_RST;
    end
    else
    begin
      status_q <= status_d;
      mask_q   <= mask_d;
    end
  end

  // Read data, zero outside the cycle after a read
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= 8'h00;
    end
    else
    begin
      rdata <= rdata_d;
    end
  end

  // Interrupt output, a level that follows the unmasked flags
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= irq_d;
    end
  end

endmodule // uic_int_id_fifo_ctrl

// ### design/uic_map.vh
`ifndef UIC_MAP_VH
`define UIC_MAP_VH

// Register addresses (word index in low address bits)
`define UIC_ADDR_W          4
`define UIC_OFF_IDFC        4'h0
`define UIC_OFF_INT_STATUS  4'h1
`define UIC_OFF_INT_MASK    4'h2

// Write-side field positions of the shared location
`define UIC_BIT_FIFO_EN     0
`define UIC_BIT_RX_RST      1
`define UIC_BIT_TX_RST      2

// Reset values
`define UIC_FIFO_EN_RST     1'b1
`define UIC_MASK_RST        2'h0

// Interrupt identification codes
`define UIC_ID_NONE         4'h1
`define UIC_ID_TXH_EMPTY    4'h2
`define UIC_ID_RX_DATA      4'h4
`define UIC_ID_LINE_STATUS  4'h6
`define UIC_ID_BUSY         4'h7
`define UIC_ID_CHAR_TMO     4'hc

// Status bit positions
`define UIC_ST_TX_RST       0
`define UIC_ST_RX_RST       1

`endif

// ### test/uic_int_id_fifo_ctrl_assertions.sv
`timescale 1ns/100ps
module uic_chk (
  input wire       clk, rst_n, wr_stb, rd_stb, pend_line_status,
  input wire [3:0] addr,
  input wire [7:0] wdata, rdata,
  input wire       fifo_enable, tx_fifo_reset, rx_fifo_reset
);
  wire w0 = wr_stb && addr == 4'h0;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Write side controls and read side code
  tx_rst_a: assert property (w0 && wdata[2] |=> tx_fifo_reset) else $error("tx");
  rx_rst_a: assert property (w0 && wdata[1] |=> rx_fifo_reset) else $error("rx");
  en_wr_a: assert property (w0 |=> fifo_enable == $past(wdata[0])) else $error("en");
  en_chg_a: assert property (w0 && wdata[0] != fifo_enable
    |=> tx_fifo_reset && rx_fifo_reset) else $error("chg");
  self_clr_a: assert property (tx_fifo_reset || rx_fifo_reset |-> $past(w0))
    else $error("clr");
  id_ls_a: assert property (rd_stb && addr == 4'h0 && pend_line_status
    |=> rdata == 8'h06) else $error("id");
  rd_only_a: assert property (rdata != 8'h00 |-> $past(rd_stb)) else $error("rd");
  cover property (w0 && wdata[0] != fifo_enable);
  cover property (w0 && wdata[1]);
  cover property (rd_stb && pend_line_status);
endmodule // uic_chk
bind uic_int_id_fifo_ctrl uic_chk i_uic_chk (.*);

// ### test/tb_uic_int_id_fifo_ctrl.sv
`timescale 1ns/100ps
module tb_uic_int_id_fifo_ctrl;
  logic        clk = 0, rst_n = 0, wr_stb = 0, rd_stb = 0, irq, en, txr, rxr;
  logic [3:0]  addr = 0;
  logic [7:0]  wdata = 0, rdata;
  logic [4:0]  pend = 0;
  int          failures = 0, n_tests = 0;
  wire  [7:0]  ctl = {4'h0, irq, txr, rxr, en};
  // Rows: pending {ls,rx,tmo,txh,busy} and code; address, data, two control states
  logic [8:0]  rrow [10] = '{9'h001, 9'h106, 9'h084, 9'h04c, 9'h022, 9'h017,
                             9'h1f6, 9'h0f4, 9'h07c, 9'h032};
  logic [27:0] wrow [8] = '{28'h2030101, 28'h0050d09, 28'h1010101, 28'hf070101,
                            28'h0030b09, 28'h1020101, 28'h0000e08, 28'h0000808};
  uic_int_id_fifo_ctrl i_uic_int_id_fifo_ctrl (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .pend_line_status(pend[4]), .pend_rx_data(pend[3]), .pend_char_tmo(pend[2]),
    .pend_tx_holding_empty(pend[1]), .pend_busy(pend[0]), .fifo_enable(en),
    .tx_fifo_reset(txr), .rx_fifo_reset(rxr), .irq(irq));
  // Compare and bus access
  task automatic chk(string n, logic [7:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic acc(logic [3:0] a, logic [7:0] d, logic w);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= w;
    rd_stb <= !w;
    @(posedge clk);
    wr_stb <= 0;
    rd_stb <= 0;
    #1;
  endtask
  task report_and_stop;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial forever #5 clk = ~clk;
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    chk("reset", 8'h01, ctl);
    rst_n <= 1;
    foreach (rrow[i])
    begin
      @(posedge clk);
      pend <= rrow[i][8:4];
      acc(4'h0, 8'h00, 0);
      chk("id", {4'h0, rrow[i][3:0]}, rdata);
    end
    $display("id test done");
    @(posedge clk);
    pend <= 0;
    foreach (wrow[i])
    begin
      acc(wrow[i][27:24], wrow[i][23:16], 1);
      chk("ctl", wrow[i][15:8], ctl);
      @(posedge clk);
      #1;
      chk("ctl", wrow[i][7:0], ctl);
    end
    $display("write test done");
    acc(4'h1, 8'h00, 0);
    chk("status", 8'h03, rdata);
    acc(4'h0, 8'h00, 0);
    chk("id", 8'h01, rdata);
    acc(4'hf, 8'h00, 0);
    chk("unmapped", 8'h00, rdata);
    acc(4'h2, 8'h00, 0);
    chk("mask", 8'h03, rdata);
    @(posedge clk);
    pend <= 5'h10;
    acc(4'h0, 8'h07, 1);
    acc(4'h0, 8'h00, 0);
    chk("id", 8'h06, rdata);
    $display("read back test done");
    @(posedge clk);
    rst_n <= 0;
    pend <= 0;
    repeat (2) @(posedge clk);
    #1;
    chk("reset", 8'h01, ctl);
    @(posedge clk);
    rst_n <= 1;
    acc(4'h1, 8'h00, 0);
    chk("status", 8'h00, rdata);
    $display("reset test done");
    report_and_stop();
  end
endmodule // tb_uic_int_id_fifo_ctrl
